/* File: hdl/mpr_pkg.sv */
// constants and types shared by the motor parameter register bank
package mpr_pkg;

    // ****************
    // clock and link timing
    // ****************
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned FIELD_CYC      = 500;
    localparam int unsigned TIMEOUT_FIELDS = 3;
    localparam int unsigned RECOVER_FIELDS = 4;
    localparam logic [15:0] TIMEOUT_CYC    = 16'(TIMEOUT_FIELDS * FIELD_CYC);
    localparam logic [15:0] RECOVER_CYC    = 16'(RECOVER_FIELDS * FIELD_CYC);

    // ****************
    // register map
    // ****************
    localparam int unsigned NREG = 8;
    localparam logic [15:0] ADDR_STATUS = 16'h0219;
    localparam logic [7:0][15:0] REG_ADDR = {16'h0116, 16'h0114, 16'h0113, 16'h0112,
                                             16'h0111, 16'h0110, 16'h010e, 16'h010d};
    localparam logic [7:0][7:0]  REG_MASK = {8'h0c, 8'hff, 8'hff, 8'h03,
                                             8'hf0, 8'h08, 8'h03, 8'h03};
    localparam logic [7:0]  REG_RESET = 8'h00;
    localparam logic [2:0]  IDX_AVG   = 3'h0;
    localparam logic [2:0]  IDX_BLANK = 3'h1;
    localparam logic [2:0]  IDX_LOCK  = 3'h2;
    localparam logic [2:0]  IDX_OFF   = 3'h3;
    localparam logic [2:0]  IDX_STEP  = 3'h4;
    localparam logic [2:0]  IDX_LTIM  = 3'h5;
    localparam logic [2:0]  IDX_ALRM  = 3'h6;
    localparam logic [2:0]  IDX_IGN   = 3'h7;

    // ****************
    // field positions
    // ****************
    localparam int unsigned LOCK_DIS_BIT = 3;
    localparam int unsigned OFF_LSB      = 4;
    localparam int unsigned TACH_LSB     = 6;
    localparam int unsigned LPER_LSB     = 4;
    localparam int unsigned RLS_LSB      = 6;
    localparam int unsigned IGN_LSB      = 2;
    localparam int unsigned RW_WRITE_BIT = 0;
    localparam int unsigned ERR_RW       = 6;
    localparam int unsigned ERR_TMO      = 5;
    localparam int unsigned ERR_CHK      = 4;
    localparam int unsigned ERR_LPAR     = 3;
    localparam int unsigned ERR_RWPAR    = 2;
    localparam int unsigned ERR_HDR      = 1;
    localparam int unsigned ERR_FRM      = 0;

    // ****************
    // decode tables
    // ****************
    localparam logic [3:0][4:0]  AVG_SAMPLES = {5'h10, 5'h08, 5'h04, 5'h00};
    localparam logic [3:0][13:0] BLANK_NS    = {14'd4000, 14'd2000, 14'd1000, 14'd500};
    localparam logic [3:0][13:0] TACH_MS     = {14'd950, 14'd850, 14'd700, 14'd400};
    localparam logic [3:0][13:0] LOCK_MS     = {14'd9000, 14'd7700, 14'd5500, 14'd3500};
    localparam int unsigned STEP_BASE_PULSES = 64;
    localparam int unsigned RPM_SPLIT        = 16;
    localparam int unsigned RPM_LO_BASE      = 500;
    localparam int unsigned RPM_LO_STEP      = 100;
    localparam int unsigned RPM_HI_BASE      = 2200;
    localparam int unsigned RPM_HI_STEP      = 200;
    localparam int unsigned IGN_STEP_MS      = 500;

    typedef enum logic [1:0] {
        MPR_STANDBY = 2'b00,
        MPR_COMM    = 2'b01,
        MPR_ERROR   = 2'b10
    } mpr_mode_t;

endpackage

/* File: hdl/mpr_param_decode.sv */
// decode of parameter register codes into engineering values
`timescale 1ns/100ps

module mpr_param_decode
    import mpr_pkg::*;
(
    input  wire logic [1:0]  avg_code,
    input  wire logic [1:0]  blank_code,
    input  wire logic [1:0]  step_code,
    input  wire logic [1:0]  tach_code,
    input  wire logic [1:0]  lper_code,
    input  wire logic [1:0]  rls_code,
    input  wire logic [1:0]  ign_code,
    input  wire logic [5:0]  det_code,
    input  wire logic        slope_select,
    output logic      [4:0]  avg_samples,
    output logic      [7:0]  blank_cycles,
    output logic      [9:0]  step_pulses,
    output logic      [9:0]  tach_wait_ms,
    output logic      [13:0] lock_period_ms,
    output logic      [13:0] detect_rpm,
    output logic      [14:0] release_rpm,
    output logic      [10:0] ignore_ms
);

    logic [2:0] rls_shift;

    always_comb
    begin
        avg_samples    = AVG_SAMPLES[avg_code];
        blank_cycles   = 8'((32'(BLANK_NS[blank_code]) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
        step_pulses    = slope_select ? 10'(STEP_BASE_PULSES << step_code) : 10'h000;
        tach_wait_ms   = 10'(TACH_MS[tach_code]);
        lock_period_ms = LOCK_MS[lper_code];
        detect_rpm = (32'(det_code) < RPM_SPLIT) ? 14'(RPM_LO_BASE + RPM_LO_STEP * 32'(det_code))
                   : 14'(RPM_HI_BASE + RPM_HI_STEP * (32'(det_code) - RPM_SPLIT));
        rls_shift      = 3'h4 - {1'b0, rls_code};
        release_rpm    = {1'b0, detect_rpm} + 15'(detect_rpm >> rls_shift);
        ignore_ms      = 11'(IGN_STEP_MS * 32'(ign_code));
    end

endmodule

/* File: hdl/mpr_regs.sv */
// motor parameter register bank with link error status
// Functional notes
// - averaging field picks none, 4, 8 or 16 input duty samples
// - blanking field picks 0.5, 1, 2 or 4 us recovery ignore time
// - lock control bit 0 enables, 1 disables locked-rotor protection
// - upper nibble code sets commutation drive-off period, passed out raw
// - with slope select set, duty rises 0.1% per 64..512 pulses
// - tach wait field picks 0.4, 0.7, 0.85 or 0.95 s
// - lock period field picks 3.5, 5.5, 7.7 or 9.0 s
// - alarm mask level nibble is passed out raw
// - alarm release at detect speed plus 1/16, 1/8, 1/4 or 1/2
// - detect code maps to 500..2000 then 2200..11600 rpm
// - start-up ignore picks 0, 0.5, 1.0 or 1.5 s
// - read-only seven-bit error status register
// - nonzero rw bits 5:1 set bit 6, stay linked, drop writes
// - gap over three fields sets bit 5 and returns to standby
// - bad write checksum sets bit 4, error state, data dropped
// - length parity sets bit 3, rw parity bit 2, error state
// - bad header sets bit 1, error state, data dropped
// - low stop bit sets bit 0, error state, data dropped
// - timeout keeps bytes already committed by good checksums
// - line high over four fields leaves error state for standby
// - flags hold until single-byte status read; multi-byte read keeps them
// - checksum error keeps earlier checksum-good data stored
`timescale 1ns/100ps

module mpr_regs
    import mpr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        comm_line,
    input  wire logic        frame_start,
    input  wire logic        field_done,
    input  wire logic        txn_end,
    input  wire logic        header_err,
    input  wire logic        stop_low,
    input  wire logic        len_parity_err,
    input  wire logic        rw_parity_err,
    input  wire logic        rw_valid,
    input  wire logic [7:0]  rw_data,
    input  wire logic        wr_byte_valid,
    input  wire logic [15:0] wr_addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        chk_valid,
    input  wire logic        chk_ok,
    input  wire logic        rd_req,
    input  wire logic [15:0] rd_addr,
    input  wire logic        rd_single,
    input  wire logic        slope_select,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    output logic      [1:0]  link_mode,
    output logic      [6:0]  err_flags,
    output logic      [1:0]  duty_average_count,
    output logic      [1:0]  overcurrent_blank_time,
    output logic             lock_protect_en,
    output logic      [3:0]  commutation_off_period,
    output logic      [1:0]  duty_step_rate,
    output logic      [1:0]  tach_wait_time,
    output logic      [1:0]  lock_period_sel,
    output logic      [3:0]  speed_alarm_mask_level,
    output logic      [1:0]  speed_alarm_release,
    output logic      [5:0]  speed_alarm_detect,
    output logic      [1:0]  startup_ignore,
    output logic      [4:0]  avg_samples,
    output logic      [7:0]  blank_cycles,
    output logic      [9:0]  step_pulses,
    output logic      [9:0]  tach_wait_ms,
    output logic      [13:0] lock_period_ms,
    output logic      [13:0] detect_rpm,
    output logic      [14:0] release_rpm,
    output logic      [10:0] ignore_ms
);

    // ****************
    // state
    // ****************
    typedef struct packed {
        mpr_mode_t       mode;
        logic [15:0]     gap_cnt;
        logic [15:0]     idle_cnt;
        logic            txn_write;
        logic            wr_discard;
        logic            pend_valid;
        logic [2:0]      pend_idx;
        logic [7:0]      pend_data;
        logic [7:0][7:0] regs;
        logic [6:0]      err;
        logic [7:0]      rd_data;
        logic            rd_valid;
        logic [4:0]      avg_samples;
        logic [7:0]      blank_cycles;
        logic [9:0]      step_pulses;
        logic [9:0]      tach_wait_ms;
        logic [13:0]     lock_period_ms;
        logic [13:0]     detect_rpm;
        logic [14:0]     release_rpm;
        logic [10:0]     ignore_ms;
    } mpr_state_t;

    mpr_state_t      s_q;
    mpr_state_t      s_d;
    logic [6:0]      err_set;
    logic [6:0]      err_clr;
    logic [NREG-1:0] wr_hit;
    logic [NREG-1:0] rd_hit;
    logic [2:0]      wr_idx;
    logic            wr_map;
    logic [7:0]      rd_word;
    logic            fatal;
    logic [4:0]      dec_avg;
    logic [7:0]      dec_blank;
    logic [9:0]      dec_step;
    logic [9:0]      dec_tach;
    logic [13:0]     dec_lper;
    logic [13:0]     dec_det;
    logic [14:0]     dec_rls;
    logic [10:0]     dec_ign;

    // ****************
    // address decode per register
    // ****************
    for (genvar i = 0; i < NREG; i++)
    begin : g_dec
        assign wr_hit[i] = (wr_addr == REG_ADDR[i]);
        assign rd_hit[i] = (rd_addr == REG_ADDR[i]);
    end

    always_comb
    begin
        wr_idx  = 3'h0;
        wr_map  = 1'b0;
        rd_word = 8'h00;
        for (int k = 0; k < NREG; k++)
        begin
            if (wr_hit[k])
            begin
                wr_idx = 3'(k);
                wr_map = 1'b1;
            end
            if (rd_hit[k])
            begin
                rd_word = s_q.regs[k];
            end
        end
        if (rd_addr == ADDR_STATUS)
        begin
            rd_word = {1'b0, s_q.err};
        end
    end

    // ****************
    // parameter decode
    // ****************
    mpr_param_decode u_decode (
        .avg_code       (s_q.regs[IDX_AVG][1:0]),
        .blank_code     (s_q.regs[IDX_BLANK][1:0]),
        .step_code      (s_q.regs[IDX_STEP][1:0]),
        .tach_code      (s_q.regs[IDX_LTIM][TACH_LSB +: 2]),
        .lper_code      (s_q.regs[IDX_LTIM][LPER_LSB +: 2]),
        .rls_code       (s_q.regs[IDX_ALRM][RLS_LSB +: 2]),
        .ign_code       (s_q.regs[IDX_IGN][IGN_LSB +: 2]),
        .det_code       (s_q.regs[IDX_ALRM][5:0]),
        .slope_select   (slope_select),
        .avg_samples    (dec_avg),
        .blank_cycles   (dec_blank),
        .step_pulses    (dec_step),
        .tach_wait_ms   (dec_tach),
        .lock_period_ms (dec_lper),
        .detect_rpm     (dec_det),
        .release_rpm    (dec_rls),
        .ignore_ms      (dec_ign)
    );

    // ****************
    // next state
    // ****************
    always_comb
    begin
        s_d         = s_q;
        err_set     = 7'h00;
        err_clr     = 7'h00;
        s_d.rd_valid = 1'b0;
        unique case (s_q.mode)
            MPR_STANDBY:
            begin
                if (frame_start)
                begin
                    s_d.mode       = MPR_COMM;
                    s_d.gap_cnt    = 16'h0000;
                    s_d.txn_write  = 1'b0;
                    s_d.wr_discard = 1'b0;
                    s_d.pend_valid = 1'b0;
                end
            end
            MPR_COMM:
            begin
                s_d.gap_cnt = field_done ? 16'h0000 : s_q.gap_cnt + 16'h0001;
                if (rw_valid)
                begin
                    s_d.txn_write = rw_data[RW_WRITE_BIT];
                    if (|rw_data[5:1])
                    begin
                        err_set[ERR_RW] = 1'b1;
                        s_d.wr_discard  = 1'b1;
                    end
                end
                if (chk_valid)
                begin
                    if (chk_ok && s_q.pend_valid)
                    begin
                        s_d.regs[s_q.pend_idx] = s_q.pend_data & REG_MASK[s_q.pend_idx];
                    end
                    if (!chk_ok && s_q.txn_write)
                    begin
                        err_set[ERR_CHK] = 1'b1;
                    end
                    s_d.pend_valid = 1'b0;
                end
                if (wr_byte_valid && s_q.txn_write && !s_d.wr_discard && wr_map)
                begin
                    s_d.pend_valid = 1'b1;
                    s_d.pend_idx   = wr_idx;
                    s_d.pend_data  = wr_data;
                end
                if (rd_req)
                begin
                    s_d.rd_data  = rd_word;
                    s_d.rd_valid = 1'b1;
                    if (rd_addr == ADDR_STATUS && rd_single)
                    begin
                        err_clr = 7'h7f;
                    end
                end
                if (txn_end)
                begin
                    s_d.mode = MPR_STANDBY;
                end
                if (s_q.gap_cnt > TIMEOUT_CYC)
                begin
                    err_set[ERR_TMO] = 1'b1;
                    s_d.mode         = MPR_STANDBY;
                    s_d.pend_valid   = 1'b0;
                end
            end
            MPR_ERROR:
            begin
                s_d.idle_cnt = comm_line ? s_q.idle_cnt + 16'h0001 : 16'h0000;
                if (s_q.idle_cnt > RECOVER_CYC)
                begin
                    s_d.mode = MPR_STANDBY;
                end
            end
            default:
            begin
                s_d.mode = MPR_STANDBY;
            end
        endcase
        if (s_q.mode != MPR_ERROR)
        begin
            err_set[ERR_HDR]   = header_err;
            err_set[ERR_FRM]   = stop_low;
            err_set[ERR_LPAR]  = len_parity_err;
            err_set[ERR_RWPAR] = rw_parity_err;
        end
        fatal = |err_set[ERR_CHK:ERR_FRM];
        if (fatal)
        begin
            s_d.mode       = MPR_ERROR;
            s_d.idle_cnt   = 16'h0000;
            s_d.pend_valid = 1'b0;
        end
        s_d.err            = (s_q.err & ~err_clr) | err_set;
        s_d.avg_samples    = dec_avg;
        s_d.blank_cycles   = dec_blank;
        s_d.step_pulses    = dec_step;
        s_d.tach_wait_ms   = dec_tach;
        s_d.lock_period_ms = dec_lper;
        s_d.detect_rpm     = dec_det;
        s_d.release_rpm    = dec_rls;
        s_d.ignore_ms      = dec_ign;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    // ****************
    // outputs
    // ****************
    assign rd_data   = s_q.rd_data;
    assign rd_valid  = s_q.rd_valid;
    assign link_mode = s_q.mode;
    assign err_flags = s_q.err;

    assign duty_average_count     = s_q.regs[IDX_AVG][1:0];
    assign overcurrent_blank_time = s_q.regs[IDX_BLANK][1:0];
    assign lock_protect_en        = ~s_q.regs[IDX_LOCK][LOCK_DIS_BIT];
    assign commutation_off_period = s_q.regs[IDX_OFF][OFF_LSB +: 4];
    assign duty_step_rate         = s_q.regs[IDX_STEP][1:0];
    assign tach_wait_time         = s_q.regs[IDX_LTIM][TACH_LSB +: 2];
    assign lock_period_sel        = s_q.regs[IDX_LTIM][LPER_LSB +: 2];
    assign speed_alarm_mask_level = s_q.regs[IDX_LTIM][3:0];
    assign speed_alarm_release    = s_q.regs[IDX_ALRM][RLS_LSB +: 2];
    assign speed_alarm_detect     = s_q.regs[IDX_ALRM][5:0];
    assign startup_ignore         = s_q.regs[IDX_IGN][IGN_LSB +: 2];

    assign avg_samples    = s_q.avg_samples;
    assign blank_cycles   = s_q.blank_cycles;
    assign step_pulses    = s_q.step_pulses;
    assign tach_wait_ms   = s_q.tach_wait_ms;
    assign lock_period_ms = s_q.lock_period_ms;
    assign detect_rpm     = s_q.detect_rpm;
    assign release_rpm    = s_q.release_rpm;
    assign ignore_ms      = s_q.ignore_ms;

endmodule

/* File: bench/mpr_regs_properties.sv */
// port assertions for the parameter register bank
`timescale 1ns/100ps
module mpr_regs_properties
    import mpr_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        comm_line,
    input wire logic        field_done,
    input wire logic        stop_low,
    input wire logic        header_err,
    input wire logic        rw_valid,
    input wire logic [7:0]  rw_data,
    input wire logic        rd_req,
    input wire logic [15:0] rd_addr,
    input wire logic        rd_single,
    input wire logic        rd_valid,
    input wire logic [7:0]  rd_data,
    input wire logic [1:0]  link_mode,
    input wire logic [6:0]  err_flags
);
    logic [15:0] gap_q;
    logic [15:0] idle_q;
    logic        comm;
    assign comm = ce && link_mode == MPR_COMM;
    // ****************
    // gap and idle counters
    // ****************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            {gap_q, idle_q} <= 32'h0;
        else
        begin
            gap_q  <= (link_mode == MPR_COMM && !field_done) ? gap_q + 16'h1 : 16'h0;
            idle_q <= (link_mode == MPR_ERROR && comm_line) ? idle_q + 16'h1 : 16'h0;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_fatal;
        ce && link_mode != MPR_ERROR && (stop_low || header_err);
    endsequence
    sequence s_err;
        link_mode == MPR_ERROR [*2];
    endsequence
    property p_st_rd;
        comm && rd_req && rd_addr == ADDR_STATUS |=> rd_valid && rd_data[7] == 1'b0
            && (rd_data[6:0] & $past(err_flags)) == $past(err_flags);
    endproperty
    a_st_rd: assert property (p_st_rd) else $error("status read lost a flag");
    property p_hold;
        !(comm && rd_req && rd_single && rd_addr == ADDR_STATUS)
            |=> (err_flags & $past(err_flags)) == $past(err_flags);
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped without read");
    property p_rw;
        comm && rw_valid && rw_data[5:1] != 5'h0 |=> err_flags[ERR_RW] && link_mode == MPR_COMM;
    endproperty
    a_rw: assert property (p_rw) else $error("rw field error missed");
    property p_fatal;
        s_fatal |=> s_err;
    endproperty
    a_fatal: assert property (p_fatal) else $error("no error mode after fault");
    property p_chk;
        $rose(err_flags[ERR_CHK]) |-> link_mode == MPR_ERROR;
    endproperty
    a_chk: assert property (p_chk) else $error("checksum flag without error mode");
    property p_tmo;
        gap_q > TIMEOUT_CYC + 16'h5 |-> link_mode != MPR_COMM;
    endproperty
    a_tmo: assert property (p_tmo) else $error("gap timeout missed");
    property p_tmo_flag;
        $fell(link_mode == MPR_COMM) && gap_q > TIMEOUT_CYC - 16'h8
            |-> err_flags[ERR_TMO] && link_mode == MPR_STANDBY;
    endproperty
    a_tmo_flag: assert property (p_tmo_flag) else $error("timeout flag or mode wrong");
    property p_recover;
        idle_q > RECOVER_CYC + 16'h5 |-> link_mode != MPR_ERROR;
    endproperty
    a_recover: assert property (p_recover) else $error("error mode not left");
endmodule

bind mpr_regs mpr_regs_properties u_props (.*);

/* File: bench/mpr_link_master.sv */
// serial master model driving the link front-end pulses
`timescale 1ns/100ps
module mpr_link_master
(
    input  wire logic        ref_clk,
    output logic             comm_line,
    output logic             frame_start,
    output logic             field_done,
    output logic             txn_end,
    output logic             header_err,
    output logic             stop_low,
    output logic             len_parity_err,
    output logic             rw_parity_err,
    output logic             rw_valid,
    output logic      [7:0]  rw_data,
    output logic             wr_byte_valid,
    output logic      [15:0] wr_addr,
    output logic      [7:0]  wr_data,
    output logic             chk_valid,
    output logic             chk_ok,
    output logic             rd_req,
    output logic      [15:0] rd_addr,
    output logic             rd_single
);
    initial
    begin
        comm_line = 1'b1;
        {frame_start, field_done, txn_end, header_err, stop_low, len_parity_err} = 6'h0;
        {rw_parity_err, rw_valid, wr_byte_valid, chk_valid, chk_ok, rd_req, rd_single} = 7'h0;
        {rw_data, wr_data, wr_addr, rd_addr} = 48'h0;
    end
    task automatic set_line(input logic v);
        @(posedge ref_clk);
        comm_line <= v;
    endtask
    task automatic open_txn(input logic [7:0] rw);
        @(posedge ref_clk);
        comm_line   <= 1'b0;
        frame_start <= 1'b1;
        @(posedge ref_clk);
        frame_start <= 1'b0;
        rw_valid    <= 1'b1;
        rw_data     <= rw;
        @(posedge ref_clk);
        rw_valid    <= 1'b0;
        rw_data     <= ~rw;
        #1;
    endtask
    task automatic send_byte(input logic [15:0] a, input logic [7:0] d, input logic ok,
                             input logic chk);
        @(posedge ref_clk);
        wr_byte_valid <= 1'b1;
        wr_addr       <= a;
        wr_data       <= d;
        @(posedge ref_clk);
        wr_byte_valid <= 1'b0;
        wr_addr       <= ~a;
        wr_data       <= ~d;
        chk_valid     <= chk;
        chk_ok        <= ok;
        @(posedge ref_clk);
        chk_valid     <= 1'b0;
        chk_ok        <= ~ok;
        field_done    <= chk;
        @(posedge ref_clk);
        field_done    <= 1'b0;
        #1;
    endtask
    task automatic read_reg(input logic [15:0] a, input logic s);
        @(posedge ref_clk);
        rd_req    <= 1'b1;
        rd_addr   <= a;
        rd_single <= s;
        @(posedge ref_clk);
        rd_req    <= 1'b0;
        rd_addr   <= ~a;
        #1;
    endtask
    task automatic close_txn();
        @(posedge ref_clk);
        txn_end   <= 1'b1;
        @(posedge ref_clk);
        txn_end   <= 1'b0;
        comm_line <= 1'b1;
        #1;
    endtask
    task automatic fault(input int k);
        @(posedge ref_clk);
        {rw_parity_err, len_parity_err, stop_low, header_err} <= 4'(1 << k);
        @(posedge ref_clk);
        {rw_parity_err, len_parity_err, stop_low, header_err} <= 4'h0;
        #1;
    endtask
endmodule

/* File: bench/mpr_regs_test.sv */
// self-checking bench for the parameter register bank
`timescale 1ns/100ps
module mpr_regs_test
    import mpr_pkg::*;
;
    logic        ref_clk, rst, ce, slope_select, rd_valid, lock_protect_en;
    logic        comm_line, frame_start, field_done, txn_end, header_err, stop_low;
    logic        len_parity_err, rw_parity_err, rw_valid, wr_byte_valid, chk_valid;
    logic        chk_ok, rd_req, rd_single;
    logic [15:0] wr_addr, rd_addr;
    logic [7:0]  rw_data, wr_data, rd_data, blank_cycles;
    logic [6:0]  err_flags;
    logic [4:0]  avg_samples;
    logic [3:0]  commutation_off_period, speed_alarm_mask_level;
    logic [1:0]  link_mode, duty_average_count, overcurrent_blank_time, duty_step_rate;
    logic [1:0]  tach_wait_time, lock_period_sel, speed_alarm_release, startup_ignore;
    logic [5:0]  speed_alarm_detect;
    logic [9:0]  step_pulses, tach_wait_ms;
    logic [13:0] lock_period_ms, detect_rpm;
    logic [14:0] release_rpm;
    logic [10:0] ignore_ms;
    int          n_errors, tests_run, flags, m[8];
    int          seed = 71401;
    int          tach_t[4] = '{400, 700, 850, 950};
    int          lock_t[4] = '{3500, 5500, 7700, 9000};
    int          fbit[4] = '{2, 1, 8, 4};
    mpr_regs u_dut (.*);
    mpr_link_master u_m (.*);
    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic wait_mode(input logic [1:0] md, input int lim);
        for (int n = 0; n < lim && link_mode !== md; n++)
        begin
            @(posedge ref_clk);
            #1;
        end
        check("link_mode", link_mode, md);
        if (link_mode !== md)
            print_verdict();
    endtask
    task automatic recover();
        u_m.set_line(1'b1);
        wait_mode(MPR_STANDBY, RECOVER_CYC + 16);
    endtask
    task automatic wr(input int i, input int v);
        u_m.send_byte(i < 8 ? REG_ADDR[i] : ADDR_STATUS, 8'(v), 1'b1, 1'b1);
        if (i < 8)
            m[i] = v & REG_MASK[i];
    endtask
    task automatic rchk(input logic [15:0] a, input logic s, input int e);
        u_m.read_reg(a, s);
        check("rd_valid", rd_valid, 1);
        check("rd_data", rd_data, e);
    endtask
    task automatic read_all();
        u_m.open_txn(8'h00);
        for (int i = 0; i < 8; i++)
            rchk(REG_ADDR[i], 1'b1, m[i]);
        rchk(16'h0115, 1'b1, 0);
        rchk(ADDR_STATUS, 1'b1, flags);
        flags = 0;
        u_m.close_txn();
    endtask
    task automatic fields();
        int c;
        int r;
        c = m[0] & 3;
        check("avg", avg_samples, c == 0 ? 0 : 4 << (c - 1));
        check("blank", blank_cycles, 25 << (m[1] & 3));
        check("lock_en", lock_protect_en, m[2][3] ? 0 : 1);
        check("off", commutation_off_period, m[3] >> 4);
        check("step", step_pulses, slope_select ? 64 << (m[4] & 3) : 0);
        check("tach", tach_wait_ms, tach_t[m[5] >> 6]);
        check("lock", lock_period_ms, lock_t[m[5] >> 4 & 3]);
        check("mask", speed_alarm_mask_level, m[5] & 15);
        c = m[6] & 63;
        r = c < 16 ? 500 + 100 * c : 2200 + 200 * (c - 16);
        check("detect", detect_rpm, r);
        check("release", release_rpm, r + (r >> (4 - (m[6] >> 6))));
        check("ignore", ignore_ms, 500 * (m[7] >> 2 & 3));
        check("raw", {duty_average_count, overcurrent_blank_time, duty_step_rate, tach_wait_time,
            lock_period_sel, speed_alarm_release, speed_alarm_detect, startup_ignore},
            {m[0][1:0], m[1][1:0], m[4][1:0], m[5][7:4], m[6][7:0], m[7][3:2]});
    endtask
    initial
    begin
        ref_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        slope_select = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check("err_flags", err_flags, 0);
        fields();
        for (int k = 0; k < 5; k++)
        begin
            @(posedge ref_clk);
            slope_select <= k[0];
            u_m.open_txn(8'h01);
            for (int i = 0; i < 9; i++)
                wr(i, k < 4 ? k * 85 : $random(seed));
            u_m.close_txn();
            repeat (3) @(posedge ref_clk);
            #1;
            fields();
            read_all();
            $display("test round %0d done", k);
        end
        u_m.open_txn(8'h03);
        u_m.send_byte(REG_ADDR[0], 8'(m[0] ^ 3), 1'b1, 1'b1);
        check("link_mode", link_mode, MPR_COMM);
        flags |= 64;
        u_m.close_txn();
        read_all();
        $display("test rw field done");
        u_m.open_txn(8'h01);
        wr(1, 2);
        u_m.send_byte(REG_ADDR[2], 8'(m[2] ^ 8), 1'b0, 1'b1);
        flags |= 16;
        check("link_mode", link_mode, MPR_ERROR);
        recover();
        read_all();
        $display("test checksum done");
        for (int k = 0; k < 4; k++)
        begin
            u_m.open_txn(8'h01);
            u_m.fault(k);
            flags |= fbit[k];
            check("link_mode", link_mode, MPR_ERROR);
            recover();
        end
        u_m.open_txn(8'h00);
        rchk(ADDR_STATUS, 1'b0, flags);
        rchk(ADDR_STATUS, 1'b1, flags);
        rchk(ADDR_STATUS, 1'b1, 0);
        flags = 0;
        u_m.close_txn();
        $display("test faults done");
        u_m.open_txn(8'h01);
        wr(3, 8'h50);
        u_m.send_byte(REG_ADDR[4], 8'(m[4] ^ 2), 1'b1, 1'b0);
        wait_mode(MPR_STANDBY, TIMEOUT_CYC + 16);
        flags |= 32;
        u_m.set_line(1'b1);
        read_all();
        $display("test timeout done");
        print_verdict();
    end
endmodule
